// ---- bl_cfg_pkg.sv ----
// Purpose: Shared constants and types for the backlight config bank
// Assumes: 32-bit AXI4-Lite, printed offsets kept as word indexes
// Notes:   Byte address of each register is four times its index
package bl_cfg_pkg;

	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Word indexes of the registers
	localparam logic [7:0] IDX_DIM_SLOPE   = 8'hA1;
	localparam logic [7:0] IDX_BOOST_DIM   = 8'hA2;
	localparam logic [7:0] IDX_GUARD_PWM   = 8'hA3;
	localparam logic [7:0] IDX_FIXED_BOOST = 8'hB0;
	localparam logic [7:0] IDX_STATUS      = 8'hB1;

	// Byte addresses derived from the indexes
	localparam logic [ADDR_W-1:0] ADDR_DIM_SLOPE   = {2'b00, IDX_DIM_SLOPE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_BOOST_DIM   = {2'b00, IDX_BOOST_DIM, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_GUARD_PWM   = {2'b00, IDX_GUARD_PWM, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_FIXED_BOOST = {2'b00, IDX_FIXED_BOOST,
		2'b00};
	localparam logic [ADDR_W-1:0] ADDR_STATUS      = {2'b00, IDX_STATUS, 2'b00};

	// Values after reset
	localparam logic [7:0] RST_DIM_SLOPE   = 8'h00;
	localparam logic [7:0] RST_BOOST_DIM   = 8'h00;
	localparam logic [7:0] RST_GUARD_PWM   = 8'h00;
	localparam logic [7:0] RST_FIXED_BOOST = 8'h00;

	// Field positions
	localparam int BIT_AUTO_DIM     = 5; // in dim/slope register
	localparam int BIT_ADAPT_RATE   = 6; // in boost/dimming register
	localparam int BIT_SMOOTH_RAMP  = 5;
	localparam int BIT_SPLIT_SEL    = 4;
	localparam int BIT_ADAPT_EN     = 3;
	localparam int BIT_STAGGER      = 5; // in guard/pwm register
	localparam int RATE_MSB         = 4;
	localparam int RATE_LSB         = 0;

	// Adaptive pacing: update on this count value, once per sixteen PWM cycles when slow
	localparam int PACE_W = 4;
	localparam logic [PACE_W-1:0] PACE_LAST = 4'hF;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Dimming scheme in force
	typedef enum logic [1:0] {
		DIM_PWM_ONLY  = 2'b00,
		DIM_SPLIT_50  = 2'b01,
		DIM_SPLIT_25  = 2'b10
	} dim_mode_t;

	// Write channel state, one-hot
	typedef enum logic [1:0] {
		WR_IDLE = 2'b01,
		WR_RESP = 2'b10
	} wr_state_t;

endpackage

// ---- adapt_pace_if.sv ----
// Purpose: Carries PWM cycle ticks and adaptive update pulses
// Assumes: All signals on the block clock
// Notes:   Pacer drives update and count, bank drives the rest
`timescale 1ns/10ps
interface adapt_pace_if;
	logic cycle_done;
	logic slow_rate;
	logic enable;
	logic update;
	logic [3:0] count;

	modport bank  (output cycle_done, output slow_rate, output enable,
		input update, input count);
	modport pacer (input cycle_done, input slow_rate, input enable,
		output update, output count);
endinterface

// ---- adapt_pacer.sv ----
// Purpose: Paces adaptive boost updates against PWM cycles
// Assumes: cycle_done is a one-cycle pulse per PWM or phase cycle
// Notes:   Counter restarts while adaptive control is off
`timescale 1ns/10ps
module adapt_pacer
	import bl_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pacing link
	adapt_pace_if.pacer pace
);

	logic [PACE_W-1:0] count;

	// Counts PWM cycles, wraps after sixteen
	always_ff @(posedge clk) begin
		if (rst || !pace.enable) begin
			count <= '0;
		end else if (pace.cycle_done) begin
			count <= count + 4'h1;
		end
	end

	// Update every cycle, or only on the sixteenth when slow
	always_ff @(posedge clk) begin
		if (rst || !pace.enable) begin
			pace.update <= 1'b0;
		end else begin
			pace.update <= pace.cycle_done &&
				(!pace.slow_rate || count == PACE_LAST);
		end
	end

	assign pace.count = count;

endmodule

// ---- backlight_boost_pwm_config.sv ----
// Purpose: Configuration bank for boost converter and LED PWM engine
// Assumes: AXI4-Lite slave; pwm_cycle_done comes from same-clock logic
// Notes:   One write and one read handled at a time
//
// Summary of operation
// - Smooth-ramp bit set makes brightness changes use the advanced ramp.
// - Split bit picks 50% mode at 0, 25% mode at 1.
// - Adaptive bit clear holds boost at the fixed boost level.
// - Stagger bit selects phase-shifted PWM at 1, normal PWM at 0.
// - Five-bit code in bits 4:0 selects the PWM output frequency.
// - Split choice applies only with auto dimming on; else PWM only.
`timescale 1ns/10ps
module backlight_boost_pwm_config
	import bl_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// AXI4-Lite write address
	input  wire logic [bl_cfg_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output      logic                      s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [bl_cfg_pkg::DATA_W-1:0] s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output      logic                      s_axi_wready,
	// AXI4-Lite write response
	output      logic [1:0]                s_axi_bresp,
	output      logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [bl_cfg_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output      logic                      s_axi_arready,
	// AXI4-Lite read data
	output      logic [bl_cfg_pkg::DATA_W-1:0] s_axi_rdata,
	output      logic [1:0]                s_axi_rresp,
	output      logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// PWM engine tick
	input  wire logic                      pwm_cycle_done,
	// Controls to the analog and PWM logic
	output      logic                      smooth_ramp_enable,
	output      bl_cfg_pkg::dim_mode_t     dim_mode,
	output      logic                      adaptive_output_enable,
	output      logic [7:0]                boost_setpoint,
	output      logic                      boost_hold_fixed,
	output      logic                      adapt_update,
	output      logic                      phase_stagger_enable,
	output      logic [4:0]                pwm_rate_code
);

	import bl_cfg_pkg::*;

	// Register storage
	logic [7:0] dim_and_slope_config;
	logic [7:0] boost_and_dimming_config;
	logic [7:0] supply_guard_and_pwm_config;
	logic [7:0] fixed_boost_level;

	// Write channel bookkeeping
	wr_state_t             wr_state;
	logic                  aw_held;
	logic                  w_held;
	logic [ADDR_W-1:0]     aw_addr;
	logic [DATA_W-1:0]     w_data;
	logic [3:0]            w_strb;
	logic                  do_write;
	logic                  wr_hit;
	logic                  rd_hit;
	logic [DATA_W-1:0]     next_rdata;

	adapt_pace_if pace ();

	// Write address and data are ready until their beat is held; read address until rvalid
	assign s_axi_awready = (wr_state == WR_IDLE) && !aw_held;
	assign s_axi_wready  = (wr_state == WR_IDLE) && !w_held;
	assign s_axi_arready = !s_axi_rvalid;

	// Commit once address and data have both arrived
	assign do_write = (wr_state == WR_IDLE) &&
		(aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid);

	// Capture address and data in either order
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end else if (do_write) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// Effective beat contents at commit time
	logic [ADDR_W-1:0] eff_addr;
	logic [7:0]        eff_byte;
	logic              eff_lane0;
	assign eff_addr  = aw_held ? aw_addr : s_axi_awaddr;
	assign eff_byte  = w_held ? w_data[7:0] : s_axi_wdata[7:0];
	assign eff_lane0 = w_held ? w_strb[0] : s_axi_wstrb[0];

	// Address decode for writes; status is read-only
	always_comb begin
		case (eff_addr)
			ADDR_DIM_SLOPE, ADDR_BOOST_DIM, ADDR_GUARD_PWM,
			ADDR_FIXED_BOOST: begin
				wr_hit = 1'b1;
			end
			default: begin
				wr_hit = 1'b0;
			end
		endcase
	end

	// Write response sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_state     <= WR_IDLE;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			case (wr_state)
				WR_IDLE: begin
					if (do_write) begin
						wr_state     <= WR_RESP;
						s_axi_bvalid <= 1'b1;
						s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
					end
				end
				WR_RESP: begin
					if (s_axi_bready) begin
						wr_state     <= WR_IDLE;
						s_axi_bvalid <= 1'b0;
					end
				end
				default: begin
					wr_state     <= WR_IDLE;
					s_axi_bvalid <= 1'b0;
				end
			endcase
		end
	end

	// Register writes through byte lane zero
	always_ff @(posedge clk) begin
		if (rst) begin
			dim_and_slope_config        <= RST_DIM_SLOPE;
			boost_and_dimming_config    <= RST_BOOST_DIM;
			supply_guard_and_pwm_config <= RST_GUARD_PWM;
			fixed_boost_level           <= RST_FIXED_BOOST;
		end else if (do_write && eff_lane0) begin
			case (eff_addr)
				ADDR_DIM_SLOPE: begin
					dim_and_slope_config <= eff_byte;
				end
				ADDR_BOOST_DIM: begin
					boost_and_dimming_config <= eff_byte;
				end
				ADDR_GUARD_PWM: begin
					supply_guard_and_pwm_config <= eff_byte;
				end
				ADDR_FIXED_BOOST: begin
					fixed_boost_level <= eff_byte;
				end
				default: begin
				end
			endcase
		end
	end

	// Read data mux; status shows the mode in force and pacing count
	always_comb begin
		next_rdata = '0;
		rd_hit     = 1'b1;
		case (s_axi_araddr)
			ADDR_DIM_SLOPE: begin
				next_rdata[7:0] = dim_and_slope_config;
			end
			ADDR_BOOST_DIM: begin
				next_rdata[7:0] = boost_and_dimming_config;
			end
			ADDR_GUARD_PWM: begin
				next_rdata[7:0] = supply_guard_and_pwm_config;
			end
			ADDR_FIXED_BOOST: begin
				next_rdata[7:0] = fixed_boost_level;
			end
			ADDR_STATUS: begin
				next_rdata[7:0] = {pace.count, boost_hold_fixed, 1'b0,
					dim_mode};
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read response, held until taken
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Control outputs derived from the stored fields
	always_ff @(posedge clk) begin
		if (rst) begin
			smooth_ramp_enable     <= 1'b0;
			dim_mode               <= DIM_PWM_ONLY;
			adaptive_output_enable <= 1'b0;
			boost_hold_fixed       <= 1'b1;
			boost_setpoint         <= RST_FIXED_BOOST;
			phase_stagger_enable   <= 1'b0;
			pwm_rate_code          <= '0;
		end else begin
			smooth_ramp_enable <= boost_and_dimming_config[BIT_SMOOTH_RAMP];
			if (!dim_and_slope_config[BIT_AUTO_DIM]) begin
				dim_mode <= DIM_PWM_ONLY;
			end else if (boost_and_dimming_config[BIT_SPLIT_SEL]) begin
				dim_mode <= DIM_SPLIT_25;
			end else begin
				dim_mode <= DIM_SPLIT_50;
			end
			adaptive_output_enable <= boost_and_dimming_config[BIT_ADAPT_EN];
			boost_hold_fixed <= !boost_and_dimming_config[BIT_ADAPT_EN];
			boost_setpoint   <= fixed_boost_level;
			phase_stagger_enable <= supply_guard_and_pwm_config[BIT_STAGGER];
			pwm_rate_code <=
				supply_guard_and_pwm_config[RATE_MSB:RATE_LSB];
		end
	end

	// Adaptive loop pacing
	assign pace.cycle_done = pwm_cycle_done;
	assign pace.slow_rate  = boost_and_dimming_config[BIT_ADAPT_RATE];
	assign pace.enable     = boost_and_dimming_config[BIT_ADAPT_EN];
	assign adapt_update    = pace.update;

	adapt_pacer adapt_pacer_i (
		.clk  (clk),
		.rst  (rst),
		.pace (pace)
	);

endmodule

// ---- backlight_chk.sv ----
// Purpose: Port checker for the backlight config bank
// Assumes: Bound to the top module, one clock domain
// Notes:   Watches design ports only, both inputs and outputs
`timescale 1ns/10ps
module backlight_chk
	import bl_cfg_pkg::*;
(
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    rst,
	// Bus handshakes
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_wready,
	input wire logic [1:0]              s_axi_bresp,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic                    s_axi_arready,
	input wire logic [bl_cfg_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	// Controls
	input wire logic                    pwm_cycle_done,
	input wire logic                    smooth_ramp_enable,
	input wire logic                    adaptive_output_enable,
	input wire logic                    boost_hold_fixed,
	input wire logic                    adapt_update,
	input wire logic                    phase_stagger_enable,
	input wire logic [4:0]              pwm_rate_code
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Outputs tied to their causes
	a_hold_fixed: assert property (
		boost_hold_fixed == !adaptive_output_enable)
		else $error("hold flag disagrees with adaptive enable");
	a_update_cause: assert property (
		adapt_update |-> $past(pwm_cycle_done))
		else $error("adaptive update without a cycle tick");
	a_rate_write: assert property ($changed(pwm_rate_code) |->
		$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
		else $error("rate code moved without a write");
	a_stagger_write: assert property ($changed(phase_stagger_enable) |->
		$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
		else $error("stagger moved without a write");
	a_ramp_write: assert property ($changed(smooth_ramp_enable) |->
		$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
		else $error("ramp enable moved without a write");
	// Bus answers stand until taken
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_wr_refuse: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
endmodule

bind backlight_boost_pwm_config backlight_chk backlight_chk_i (.clk, .rst,
	.s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .pwm_cycle_done, .smooth_ramp_enable,
	.adaptive_output_enable, .boost_hold_fixed, .adapt_update,
	.phase_stagger_enable, .pwm_rate_code);

// ---- backlight_boost_pwm_config_tb.sv ----
// Purpose: Self-checking bench for the backlight config bank
// Assumes: Bus master tasks drive on rising edges by NBA
// Notes:   Every wait is bounded
`timescale 1ns/10ps
module backlight_boost_pwm_config_tb;
	import bl_cfg_pkg::*;
	logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, pwm_cycle_done, smooth_ramp_enable;
	logic adaptive_output_enable, boost_hold_fixed, adapt_update;
	logic phase_stagger_enable;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] boost_setpoint;
	logic [4:0] pwm_rate_code;
	dim_mode_t dim_mode;
	int fails, checks, n;

	backlight_boost_pwm_config backlight_boost_pwm_config_i (.clk, .rst,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pwm_cycle_done, .smooth_ramp_enable, .dim_mode,
		.adaptive_output_enable, .boost_setpoint, .boost_hold_fixed,
		.adapt_update, .phase_stagger_enable, .pwm_rate_code);

	// Clock generator
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task end_of_test;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask

	task timeout_chk;
		if (n >= 50) begin
			fails++;
			$display("[FAIL] %0t bus wait ran out", $time);
			end_of_test;
		end
	endtask

	// Write one word, check the response, let controls settle
	task axi_wr(input logic [11:0] a, input logic [7:0] d,
		input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			n++;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		timeout_chk;
		chk(s_axi_bresp, er);
		@(posedge clk);
	endtask

	task axi_rd(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			n++;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		s_axi_rready <= 1'b0;
		timeout_chk;
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
		@(posedge clk);
	endtask

	// Send ticks and count update pulses seen
	task ticks(input int k, input int exp_upd);
		int c;
		c = 0;
		repeat (k) begin
			pwm_cycle_done <= 1'b1;
			@(posedge clk);
			pwm_cycle_done <= 1'b0;
			@(posedge clk);
			if (adapt_update === 1'b1) c++;
			@(posedge clk);
			if (adapt_update === 1'b1) c++;
		end
		chk(c, exp_upd);
	endtask

	// Main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, pwm_cycle_done} <= 4'h0;
		{s_axi_arvalid, s_axi_rready} <= 2'b00;
		s_axi_awaddr <= 12'h000;
		s_axi_araddr <= 12'h000;
		s_axi_wdata <= 32'h0000_0000;
		s_axi_wstrb <= 4'hF;
		fails = 0;
		checks = 0;
		rst <= 1'b1;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		axi_rd(ADDR_BOOST_DIM, 32'h0000_0000, RESP_OKAY);
		chk(boost_hold_fixed, 1'b1);
		$display("reset test done");
		axi_wr(ADDR_BOOST_DIM, 8'h30, RESP_OKAY);
		chk(smooth_ramp_enable, 1'b1);
		chk(dim_mode, DIM_PWM_ONLY);
		axi_wr(ADDR_DIM_SLOPE, 8'h20, RESP_OKAY);
		chk(dim_mode, DIM_SPLIT_25);
		axi_wr(ADDR_BOOST_DIM, 8'h08, RESP_OKAY);
		chk(dim_mode, DIM_SPLIT_50);
		chk(smooth_ramp_enable, 1'b0);
		chk(boost_hold_fixed, 1'b0);
		chk(adaptive_output_enable, 1'b1);
		$display("dimming test done");
		axi_wr(ADDR_FIXED_BOOST, 8'hA5, RESP_OKAY);
		axi_wr(ADDR_BOOST_DIM, 8'h00, RESP_OKAY);
		chk(boost_setpoint, 8'hA5);
		chk(boost_hold_fixed, 1'b1);
		chk(adaptive_output_enable, 1'b0);
		axi_wr(ADDR_GUARD_PWM, 8'h3F, RESP_OKAY);
		chk({phase_stagger_enable, pwm_rate_code}, 6'h3F);
		axi_wr(ADDR_GUARD_PWM, 8'h0A, RESP_OKAY);
		chk({phase_stagger_enable, pwm_rate_code}, 6'h0A);
		axi_rd(ADDR_GUARD_PWM, 32'h0000_000A, RESP_OKAY);
		// Lane zero strobe low: answered but nothing stored
		s_axi_wstrb <= 4'h0;
		axi_wr(ADDR_GUARD_PWM, 8'h15, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axi_rd(ADDR_GUARD_PWM, 32'h0000_000A, RESP_OKAY);
		chk({phase_stagger_enable, pwm_rate_code}, 6'h0A);
		axi_wr(12'h000, 8'h55, RESP_SLVERR);
		axi_rd(12'h000, 32'h0000_0000, RESP_SLVERR);
		axi_wr(ADDR_STATUS, 8'h55, RESP_SLVERR);
		$display("pwm and bus test done");
		ticks(2, 0);
		axi_wr(ADDR_BOOST_DIM, 8'h08, RESP_OKAY);
		ticks(3, 3);
		axi_wr(ADDR_BOOST_DIM, 8'h00, RESP_OKAY);
		axi_wr(ADDR_BOOST_DIM, 8'h48, RESP_OKAY);
		ticks(15, 0);
		// Status: count 15, adaptive on, split at 50%
		axi_rd(ADDR_STATUS, 32'h0000_00F1, RESP_OKAY);
		ticks(1, 1);
		$display("pacing test done");
		end_of_test;
	end
endmodule
